// File: rtl/mtr_regs.svh
/*
  Register offsets, field positions and reset values of the terminal router.
  Included by the router module; holds definitions only.
*/
`ifndef MTR_REGS_SVH
`define MTR_REGS_SVH

// Byte address of the routing register.
`define MTR_ROUTE_ADDR 12'h08c
// Byte address of the control register (central DMA enable, output levels).
`define MTR_CTRL_ADDR 12'h080
// Byte address of the read-only terminal status register.
`define MTR_STAT_ADDR 12'h084
// Width of the decoded address.
`define MTR_ADDR_W 12

// Reset value of the routing register.
`define MTR_ROUTE_RESET 32'h0000_0000
// Writable bits of the routing register; bits 31 to 28 always read zero.
`define MTR_ROUTE_WMASK 32'h0fff_ffff
// Width of one terminal field; terminal n sits at bits 4n+3 to 4n.
`define MTR_FIELD_W 4
// Number of multifunction terminals.
`define MTR_TERMS 7

// Reset value and writable bits of the control register.
`define MTR_CTRL_RESET 32'h0000_0000
`define MTR_CTRL_WMASK 32'h0000_1f01
// Control bit of the central DMA enable.
`define MTR_CTRL_DMA_EN 0
// Lowest control bit of the general output levels 0 to 4.
`define MTR_CTRL_GPO_LSB 8

// Status layout: synchronised terminal levels, then the input captures.
`define MTR_STAT_PIN_LSB 0
`define MTR_STAT_GPI_LSB 8
`define MTR_STAT_SERIAL 16
`define MTR_STAT_DMA_GNT 17
`define MTR_STAT_VSTAT 18
`define MTR_STAT_LOCK 19

// Terminals that carry the serial clock and the serial data in serial mode.
`define MTR_SCL_TERM 4
`define MTR_SDA_TERM 1

`endif

// File: rtl/mtr_pkg.sv
/*
  Types shared by the terminal router: function kinds, decoded routes,
  the bus request carrier and the router's state.
  Assumes the constants of mtr_regs.svh for field widths.
*/
`include "mtr_regs.svh"

package mtr_pkg;

  // Function that a terminal code selects.
  typedef enum logic [3:0] {
    MTR_K_NONE = 4'h0,
    MTR_K_GPI = 4'h1,
    MTR_K_GPO = 4'h2,
    MTR_K_IRQ = 4'h3,
    MTR_K_DMA_REQ = 4'h4,
    MTR_K_DMA_GNT = 4'h5,
    MTR_K_LOCK = 4'h6,
    MTR_K_VSTAT = 4'h7,
    MTR_K_VSEL = 4'h8,
    MTR_K_AUDIO = 4'h9,
    MTR_K_LED = 4'ha,
    MTR_K_EVENT = 4'hb,
    MTR_K_RI = 4'hc,
    MTR_K_SERIRQ = 4'hd,
    MTR_K_CLKRUN = 4'he,
    MTR_K_INTA = 4'hf
  } mtr_kind_t;

  // A decoded terminal code: its kind and an interrupt or general index.
  typedef struct packed {
    mtr_kind_t kind;
    logic [3:0] num;
  } mtr_route_t;

  // APB request signals from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`MTR_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } mtr_apb_req_t;

  // Whole state of the router.
  typedef struct packed {
    logic [31:0] route;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic slverr;
    logic [`MTR_TERMS-1:0] pin_out;
    logic [`MTR_TERMS-1:0] pin_oe;
    logic [4:0] gpi;
    logic dma_grant;
    logic video_status;
    logic lock_in;
    logic sda_in;
  } mtr_state_t;

endpackage

// File: rtl/mtr_pin_sync.sv
/*
  Three-stage synchroniser for a group of asynchronous terminal levels.
  Assumes the inputs may change at any time relative to pclk.
*/
`timescale 1ns/1ps

module mtr_pin_sync #(
  parameter int W = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level
);
  import mtr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State: three stages and the accepted level.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } mtr_sync_t;

  mtr_sync_t state_reg; // Registered state.
  mtr_sync_t state_next; // Next state.

  // A change is accepted only when stages two and three agree, so a level
  // caught mid-transition in stage one never reaches the logic.
  always_comb begin
    state_next = state_reg;
    state_next.s1 = async_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (state_reg.s2[i] == state_reg.s3[i]) begin
        state_next.lvl[i] = state_reg.s3[i];
      end
    end
  end

  // Stages clear to zero under reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.lvl;
endmodule

// File: rtl/mtr_router.sv
/*
  Multifunction terminal router: an APB register file whose routing
  register chooses the function of each of seven multifunction terminals.
  Assumes internal sources and sinks on pclk, terminal inputs and straps
  asynchronous, and an EEPROM loader that presents one word at init.
*/
// Design decision made here: register access over APB.
`timescale 1ns/1ps

`include "mtr_regs.svh"

// What this block does
// - After reset terminals 0-2, 4 and 5 are general inputs; 3 and 6 reserved.
// - EEPROM word may replace routing register contents.
// - Routing bits 31-28 read-only, read zero.
// - Terminal 6: clock-run or interrupts 2-15.
// - Terminal 5 map per bits 23-20.
// - Terminal 4 codes 0000-0110 per bits 19-16.
// - Terminal 4 codes 1000-1110 per bits 19-16.
// - Serial straps high: terminal 4 carries serial clock.
// - Terminal 3: serialized interrupt or interrupts 2-15.
// - Terminal 2 map per bits 11-8.
// - Terminals 1 and 0 at bits 7-4, 3-0.
// - DMA request/grant need central DMA enable.

module mtr_router (
  input wire logic pclk,
  input wire logic presetn,
  input wire mtr_pkg::mtr_apb_req_t apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [`MTR_TERMS-1:0] terminal_in,
  output logic [`MTR_TERMS-1:0] terminal_out,
  output logic [`MTR_TERMS-1:0] terminal_oe,
  input wire logic serial_strap_0,
  input wire logic serial_strap_1,
  input wire logic eeprom_load_valid,
  input wire logic [31:0] eeprom_load_data,
  input wire logic eeprom_scl_out,
  input wire logic eeprom_scl_oe,
  input wire logic eeprom_sda_out,
  input wire logic eeprom_sda_oe,
  output logic eeprom_sda_in,
  output logic serial_mode,
  input wire logic [15:0] irq_lines,
  input wire logic pci_inta,
  input wire logic dma_request,
  input wire logic video_port_select,
  input wire logic card_audio_pwm,
  input wire logic socket_activity_led,
  input wire logic general_event_out,
  input wire logic ring_indicate_out,
  input wire logic serialized_interrupt,
  input wire logic clock_run,
  output logic [4:0] general_input,
  output logic dma_grant,
  output logic video_port_status,
  output logic pci_lock_in,
  output logic central_dma_enable
);
  import mtr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  mtr_state_t state_reg; // Registered state of the whole block.
  mtr_state_t state_next; // Next state, built by the one combinational process.
  logic [8:0] sync_level; // Synchronised terminals (6..0) and straps (8,7).
  logic [15:0] src; // Internal output signals indexed by function kind.

  //////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Says whether a byte address names one of the three registers.
  function automatic logic mapped(input logic [`MTR_ADDR_W-1:0] a);
    mapped = (a == `MTR_ROUTE_ADDR) || (a == `MTR_CTRL_ADDR) || (a == `MTR_STAT_ADDR);
  endfunction

  // Builds a decoded route from a kind and an index.
  function automatic mtr_route_t mk(input mtr_kind_t k, input logic [3:0] n);
    mk.kind = k;
    mk.num = n;
  endfunction

  // Decodes the four-bit code of one terminal into its function.
  function automatic mtr_route_t decode_term(input int unsigned t, input logic [3:0] c);
    mtr_route_t r;
    logic [3:0] gp;
    r = mk(MTR_K_NONE, 4'h0);
    // General index: terminals 0 to 2 own index t, terminals 4 and 5 own t-1.
    gp = (t > 3) ? 4'(t - 1) : 4'(t);
    case (t)
      6: begin
        // Code zero is reserved; the rest name clock-run or a line.
        if (c == 4'h1) begin
          r = mk(MTR_K_CLKRUN, 4'h0);
        end else if (c != 4'h0) begin
          r = mk(MTR_K_IRQ, c);
        end
      end
      3: begin
        // Same layout as terminal 6 with the serialized stream at 0001.
        if (c == 4'h1) begin
          r = mk(MTR_K_SERIRQ, 4'h0);
        end else if (c != 4'h0) begin
          r = mk(MTR_K_IRQ, c);
        end
      end
      5: begin
        case (c)
          4'h0: r = mk(MTR_K_GPI, gp);
          4'h1: r = mk(MTR_K_GPO, gp);
          4'h2: r = mk(MTR_K_DMA_GNT, 4'h0);
          4'h3, 4'h4, 4'h9, 4'ha, 4'hb, 4'hf: r = mk(MTR_K_IRQ, c);
          4'h6: r = mk(MTR_K_VSTAT, 4'h0);
          4'h7: r = mk(MTR_K_VSEL, 4'h0);
          4'h8: r = mk(MTR_K_AUDIO, 4'h0);
          4'hc, 4'hd: r = mk(MTR_K_LED, 4'h0);
          4'he: r = mk(MTR_K_EVENT, 4'h0);
          default: r = mk(MTR_K_NONE, 4'h0);
        endcase
      end
      4: begin
        case (c)
          4'h0: r = mk(MTR_K_GPI, gp);
          4'h1: r = mk(MTR_K_GPO, gp);
          4'h2: r = mk(MTR_K_LOCK, 4'h0);
          4'h4, 4'h5: r = mk(MTR_K_IRQ, c);
          4'h6: r = mk(MTR_K_VSTAT, 4'h0);
          4'h8: r = mk(MTR_K_AUDIO, 4'h0);
          4'h9, 4'ha: r = mk(MTR_K_IRQ, c);
          4'hc: r = mk(MTR_K_RI, 4'h0);
          4'hd: r = mk(MTR_K_LED, 4'h0);
          4'he: r = mk(MTR_K_EVENT, 4'h0);
          default: r = mk(MTR_K_NONE, 4'h0);
        endcase
      end
      2: begin
        case (c)
          4'h0: r = mk(MTR_K_GPI, gp);
          4'h1: r = mk(MTR_K_GPO, gp);
          4'h2: r = mk(MTR_K_DMA_REQ, 4'h0);
          4'h3, 4'h4, 4'h5, 4'h9, 4'ha, 4'hb: r = mk(MTR_K_IRQ, c);
          4'h6: r = mk(MTR_K_VSTAT, 4'h0);
          4'h7: r = mk(MTR_K_VSEL, 4'h0);
          4'h8: r = mk(MTR_K_AUDIO, 4'h0);
          4'hc: r = mk(MTR_K_RI, 4'h0);
          4'he: r = mk(MTR_K_EVENT, 4'h0);
          4'hf: r = mk(MTR_K_IRQ, 4'h7);
          default: r = mk(MTR_K_NONE, 4'h0);
        endcase
      end
      default: begin
        // Terminals 1 and 0 share one map; only code 0010 differs.
        case (c)
          4'h0: r = mk(MTR_K_GPI, gp);
          4'h1: r = mk(MTR_K_GPO, gp);
          4'h2: r = (t == 0) ? mk(MTR_K_INTA, 4'h0) : mk(MTR_K_NONE, 4'h0);
          4'h3, 4'h4, 4'h5, 4'h9, 4'ha, 4'hb, 4'hd, 4'hf: r = mk(MTR_K_IRQ, c);
          4'h6: r = mk(MTR_K_VSTAT, 4'h0);
          4'h7: r = mk(MTR_K_VSEL, 4'h0);
          4'h8: r = mk(MTR_K_AUDIO, 4'h0);
          4'hc: r = mk(MTR_K_LED, 4'h0);
          4'he: r = mk(MTR_K_EVENT, 4'h0);
          default: r = mk(MTR_K_NONE, 4'h0);
        endcase
      end
    endcase
    decode_term = r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Synchroniser for terminal inputs and the serial straps.

  // One instance covers every asynchronous level, so all share a latency.
  mtr_pin_sync #(
    .W(9)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({serial_strap_1, serial_strap_0, terminal_in}),
    .level(sync_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Internal output sources gathered by kind.

  // Kinds that are inputs or that carry an index stay zero here.
  always_comb begin
    src = 16'h0000;
    src[MTR_K_DMA_REQ] = dma_request;
    src[MTR_K_VSEL] = video_port_select;
    src[MTR_K_AUDIO] = card_audio_pwm;
    src[MTR_K_LED] = socket_activity_led;
    src[MTR_K_EVENT] = general_event_out;
    src[MTR_K_RI] = ring_indicate_out;
    src[MTR_K_SERIRQ] = serialized_interrupt;
    src[MTR_K_CLKRUN] = clock_run;
    src[MTR_K_INTA] = pci_inta;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, routing and input capture.

  // Routing is computed from the registered fields, so a write is seen at the
  // terminals one edge after it is stored; the pins stay glitch-free because
  // they come straight from flip-flops.
  always_comb begin
    mtr_route_t r;
    logic smode;
    logic dma_en;
    logic setup;
    logic wr;
    r = mk(MTR_K_NONE, 4'h0);
    smode = sync_level[8] & sync_level[7];
    dma_en = state_reg.ctrl[`MTR_CTRL_DMA_EN];
    setup = apb_req.psel & ~apb_req.penable;
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite & mapped(apb_req.paddr);
    state_next = state_reg;

    // An EEPROM word replaces the routing at initialisation.
    if (eeprom_load_valid) begin
      state_next.route = eeprom_load_data & `MTR_ROUTE_WMASK;
    end

    // A software write wins over a load in the same cycle, as it is later.
    if (wr) begin
      if (apb_req.paddr == `MTR_ROUTE_ADDR) begin
        state_next.route = apb_req.pwdata & `MTR_ROUTE_WMASK;
      end else if (apb_req.paddr == `MTR_CTRL_ADDR) begin
        state_next.ctrl = apb_req.pwdata & `MTR_CTRL_WMASK;
      end
    end

    // Read data and error are captured in the setup cycle, ready for access.
    if (setup) begin
      state_next.slverr = ~mapped(apb_req.paddr);
      if (apb_req.paddr == `MTR_ROUTE_ADDR) begin
        state_next.rdata = state_reg.route & `MTR_ROUTE_WMASK;
      end else if (apb_req.paddr == `MTR_CTRL_ADDR) begin
        state_next.rdata = state_reg.ctrl;
      end else if (apb_req.paddr == `MTR_STAT_ADDR) begin
        state_next.rdata = 32'h0000_0000;
        state_next.rdata[`MTR_STAT_PIN_LSB +: `MTR_TERMS] = sync_level[`MTR_TERMS-1:0];
        state_next.rdata[`MTR_STAT_GPI_LSB +: 5] = state_reg.gpi;
        state_next.rdata[`MTR_STAT_SERIAL] = smode;
        state_next.rdata[`MTR_STAT_DMA_GNT] = state_reg.dma_grant;
        state_next.rdata[`MTR_STAT_VSTAT] = state_reg.video_status;
        state_next.rdata[`MTR_STAT_LOCK] = state_reg.lock_in;
      end else begin
        state_next.rdata = 32'h0000_0000;
      end
    end

    // Input captures default low unless a terminal currently feeds them.
    state_next.gpi = 5'h00;
    state_next.dma_grant = 1'b0;
    state_next.video_status = 1'b0;
    state_next.lock_in = 1'b0;
    state_next.sda_in = 1'b0;

    for (int t = 0; t < `MTR_TERMS; t++) begin
      // Zero codes after reset decode to general inputs, or reserved on terminals 3 and 6: nothing driven.
      r = decode_term(t, state_reg.route[t*`MTR_FIELD_W +: `MTR_FIELD_W]);
      state_next.pin_out[t] = 1'b0;
      state_next.pin_oe[t] = 1'b0;
      case (r.kind)
        MTR_K_GPI: begin
          state_next.gpi[r.num[2:0]] = sync_level[t];
        end
        MTR_K_GPO: begin
          state_next.pin_out[t] = state_reg.ctrl[`MTR_CTRL_GPO_LSB + r.num[2:0]];
          state_next.pin_oe[t] = 1'b1;
        end
        MTR_K_IRQ: begin
          state_next.pin_out[t] = irq_lines[r.num];
          state_next.pin_oe[t] = 1'b1;
        end
        MTR_K_DMA_REQ: begin
          // Without the central enable the terminal is left undriven.
          state_next.pin_out[t] = dma_en & src[MTR_K_DMA_REQ];
          state_next.pin_oe[t] = dma_en;
        end
        MTR_K_DMA_GNT: begin
          state_next.dma_grant = dma_en & sync_level[t];
        end
        MTR_K_VSTAT: begin
          state_next.video_status = sync_level[t];
        end
        MTR_K_LOCK: begin
          state_next.lock_in = sync_level[t];
        end
        MTR_K_NONE: begin
          // Reserved code: input only, no internal signal routed.
          state_next.pin_oe[t] = 1'b0;
        end
        default: begin
          state_next.pin_out[t] = src[r.kind];
          state_next.pin_oe[t] = 1'b1;
        end
      endcase
    end

    // Serial mode hands terminal 4 to the EEPROM clock and terminal 1 to its
    // data, whatever their fields say.
    if (smode) begin
      state_next.pin_out[`MTR_SCL_TERM] = eeprom_scl_out;
      state_next.pin_oe[`MTR_SCL_TERM] = eeprom_scl_oe;
      state_next.pin_out[`MTR_SDA_TERM] = eeprom_sda_out;
      state_next.pin_oe[`MTR_SDA_TERM] = eeprom_sda_oe;
      state_next.sda_in = sync_level[`MTR_SDA_TERM];
      state_next.gpi[3] = 1'b0;
      state_next.gpi[1] = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  // Routing clears to zero so every terminal starts as an input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.route <= `MTR_ROUTE_RESET;
      state_reg.ctrl <= `MTR_CTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // The slave never inserts wait states.
  assign pready = 1'b1;
  assign prdata = state_reg.rdata;
  assign pslverr = state_reg.slverr;
  assign terminal_out = state_reg.pin_out;
  assign terminal_oe = state_reg.pin_oe;
  assign eeprom_sda_in = state_reg.sda_in;
  // Serial mode is a decoded level of two synchronised straps.
  assign serial_mode = sync_level[8] & sync_level[7];
  assign general_input = state_reg.gpi;
  assign dma_grant = state_reg.dma_grant;
  assign video_port_status = state_reg.video_status;
  assign pci_lock_in = state_reg.lock_in;
  assign central_dma_enable = state_reg.ctrl[`MTR_CTRL_DMA_EN];
endmodule

// File: sim/mtr_router_chk.sv
/*
  Concurrent checks of the terminal router, seen from its top ports only.
  Assumes a single pclk domain and the asynchronous active-low presetn.
*/
`timescale 1ns/1ps
`include "mtr_regs.svh"

module mtr_router_chk
  import mtr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire mtr_pkg::mtr_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [6:0] terminal_out,
  input wire logic [6:0] terminal_oe,
  input wire logic eeprom_scl_out,
  input wire logic eeprom_scl_oe,
  input wire logic serial_mode,
  input wire logic [4:0] general_input,
  input wire logic dma_grant,
  input wire logic central_dma_enable,
  input wire logic eeprom_load_valid,
  input wire logic [31:0] eeprom_load_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////
  // Helper decode of the bus request.
  wire setup = apb_req.psel && !apb_req.penable;
  wire wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  wire at_route = apb_req.paddr == `MTR_ROUTE_ADDR;
  wire at_ctrl = apb_req.paddr == `MTR_CTRL_ADDR;
  wire mapped = at_route || at_ctrl || apb_req.paddr == `MTR_STAT_ADDR;
  logic seen_reg; // Low only until the first edge after reset.
  logic [31:0] shadow_reg; // Expected routing contents.

  // Shadow of the routing register; a bus write wins over a load.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 1'b0;
      shadow_reg <= `MTR_ROUTE_RESET;
    end else begin
      seen_reg <= 1'b1;
      if (wr_acc && at_route) begin
        shadow_reg <= apb_req.pwdata & `MTR_ROUTE_WMASK;
      end else if (eeprom_load_valid) begin
        shadow_reg <= eeprom_load_data & `MTR_ROUTE_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////
  // Read of the routing register, and access to a hole in the map.
  sequence s_rd_route;
    setup && !apb_req.pwrite && at_route;
  endsequence
  sequence s_bad;
    setup && !mapped;
  endsequence

  AST_RST_IDLE: assert property (!seen_reg |-> terminal_oe == 7'h00 && prdata == 32'h0)
    else $error("terminals driven right after reset");
  AST_TOP_ZERO: assert property (s_rd_route |=> prdata[31:28] == 4'h0)
    else $error("routing top nibble not zero");
  AST_READBACK: assert property (s_rd_route |=> prdata == $past(shadow_reg))
    else $error("routing readback differs");
  AST_UNMAP: assert property (s_bad |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_STAND: assert property (!setup |=> $stable(prdata) && $stable(pslverr))
    else $error("read answer moved outside setup");
  AST_SCL: assert property (serial_mode [*2] |-> terminal_out[4] == $past(eeprom_scl_out)
    && terminal_oe[4] == $past(eeprom_scl_oe))
    else $error("terminal 4 not carrying serial clock");
  AST_GRANT: assert property (!central_dma_enable [*2] |-> !dma_grant)
    else $error("grant without central enable");
  AST_GENERAL_INPUT_2: assert property (general_input[2] |-> !terminal_oe[2])
    else $error("terminal 2 driven while input");
  AST_GENERAL_INPUT_4: assert property (general_input[4] |-> !terminal_oe[5])
    else $error("terminal 5 driven while input");
  AST_CDMA: assert property (wr_acc && at_ctrl |=> central_dma_enable == $past(apb_req.pwdata[0]))
    else $error("central enable not written");
endmodule

bind mtr_router mtr_router_chk mtr_router_chk_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .prdata(prdata), .pslverr(pslverr), .terminal_out(terminal_out), .terminal_oe(terminal_oe),
  .eeprom_scl_out(eeprom_scl_out), .eeprom_scl_oe(eeprom_scl_oe), .serial_mode(serial_mode),
  .general_input(general_input), .dma_grant(dma_grant), .central_dma_enable(central_dma_enable),
  .eeprom_load_valid(eeprom_load_valid), .eeprom_load_data(eeprom_load_data));

// File: sim/mtr_board.sv
/*
  Board side of the seven terminals: resolves each wire from the router's
  drive and the board's own level. Assumes the board always drives a level
  where the router does not, so no terminal floats.
*/
`timescale 1ns/1ps

module mtr_board (
  input wire logic [6:0] terminal_out,
  input wire logic [6:0] terminal_oe,
  input wire logic [6:0] board_drv,
  output logic [6:0] terminal_in
);
  // The router wins where it drives; a real board would contend instead.
  assign terminal_in = (terminal_out & terminal_oe) | (board_drv & ~terminal_oe);
endmodule

// File: sim/tb_top.sv
/*
  Self-checking bench of the terminal router.
  Assumes the router, its package and register header, the board model and the checker.
*/
`timescale 1ns/1ps
`include "mtr_regs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end

module tb_top;
  import mtr_pkg::*;
  // Source index per terminal and code: 0-15 interrupt lines, 16-24 single
  // sources, 30+k general output k, -1 undriven.
  localparam int MAP[7][16] = '{
    '{-1, 30, 16, 3, 4, 5, -1, 18, 19, 9, 10, 11, 20, 13, 21, 15},
    '{-1, 31, -1, 3, 4, 5, -1, 18, 19, 9, 10, 11, 20, 13, 21, 15},
    '{-1, 32, 17, 3, 4, 5, -1, 18, 19, 9, 10, 11, 22, -1, 21, 7},
    '{-1, 23, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15},
    '{-1, 33, -1, -1, 4, 5, -1, -1, 19, 9, 10, -1, 22, 20, 21, -1},
    '{-1, 34, -1, 3, 4, -1, -1, 18, 19, 9, 10, 11, 20, 20, 21, 15},
    '{-1, 24, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15}};
  localparam logic [24:0] PAT = 25'h155_5555;
  localparam logic [4:0] GPO = 5'h15;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  mtr_apb_req_t req = '0;
  logic [24:0] src = '0;
  logic [6:0] board_drv = '0;
  logic s0 = 1'b0;
  logic s1 = 1'b0;
  logic ld_v = 1'b0;
  logic [31:0] ld_d = '0;
  logic scl_o = 1'b0;
  logic scl_oe = 1'b0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [6:0] t_in;
  logic [6:0] t_out;
  logic [6:0] t_oe;
  logic ser;
  logic [4:0] gin;
  logic grant;
  logic cdma;
  logic vst;
  logic lck;
  logic sda;
  logic [31:0] q;
  logic e;
  int n_mismatch = 0;
  int samples_checked = 0;

  ////////////////////////////////////////////////
  // Clock at 50 MHz.
  always #10 pclk = ~pclk;

  mtr_router mtr_router_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .terminal_in(t_in), .terminal_out(t_out), .terminal_oe(t_oe),
    .serial_strap_0(s0), .serial_strap_1(s1), .eeprom_load_valid(ld_v), .eeprom_load_data(ld_d),
    .eeprom_scl_out(scl_o), .eeprom_scl_oe(scl_oe), .eeprom_sda_out(scl_o), .eeprom_sda_oe(scl_oe),
    .eeprom_sda_in(sda), .serial_mode(ser), .irq_lines(src[15:0]), .pci_inta(src[16]),
    .dma_request(src[17]), .video_port_select(src[18]), .card_audio_pwm(src[19]),
    .socket_activity_led(src[20]), .general_event_out(src[21]), .ring_indicate_out(src[22]),
    .serialized_interrupt(src[23]), .clock_run(src[24]), .general_input(gin), .dma_grant(grant),
    .video_port_status(vst), .pci_lock_in(lck), .central_dma_enable(cdma));
  mtr_board mtr_board_i (.terminal_out(t_out), .terminal_oe(t_oe), .board_drv(board_drv), .terminal_in(t_in));

  ////////////////////////////////////////////////
  // Closing verdict, reached from the main flow or a stalled wait.
  task automatic wrap_up();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One bus transfer; the answer lands in q and e.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    n = 0;
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n == 16) begin
      n_mismatch++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Waits for settled outputs after k edges.
  task automatic settle(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask

  ////////////////////////////////////////////////
  // Reset contents, read-only nibble and a hole in the map.
  task automatic t_reset();
    apb(1'b0, `MTR_ROUTE_ADDR, 32'h0);
    `CHK(q, 32'h0)
    `CHK(t_oe, 7'h00)
    apb(1'b1, `MTR_ROUTE_ADDR, 32'hffff_ffff);
    apb(1'b0, `MTR_ROUTE_ADDR, 32'h0);
    `CHK(q, 32'h0fff_ffff)
    apb(1'b0, 12'h088, 32'h0);
    `CHK({e, q}, 33'h1_0000_0000)
    apb(1'b1, `MTR_ROUTE_ADDR, 32'h0);
  endtask

  // Every code of every terminal, with each source but the general outputs seen at both levels.
  task automatic t_map();
    int x;
    logic [24:0] p;
    apb(1'b1, `MTR_CTRL_ADDR, 32'h0000_1501);
    for (int t = 0; t < 7; t++) begin
      for (int c = 0; c < 16; c++) begin
        apb(1'b1, `MTR_ROUTE_ADDR, 32'(c) << (4 * t));
        for (int i = 0; i < 2; i++) begin
          p = i ? ~PAT : PAT;
          @(posedge pclk);
          src <= p;
          settle(1);
          x = MAP[t][c];
          `CHK(t_oe, x < 0 ? 7'h00 : 7'h01 << t)
          if (x >= 0) begin
            `CHK(t_out[t], x >= 30 ? GPO[x - 30] : p[x])
          end
        end
      end
    end
  endtask

  // Central DMA enable gates request and grant; general inputs capture.
  task automatic t_dma();
    apb(1'b1, `MTR_CTRL_ADDR, 32'h0);
    apb(1'b1, `MTR_ROUTE_ADDR, 32'h0000_0200);
    settle(1);
    `CHK(t_oe[2], 1'b0)
    @(posedge pclk);
    board_drv <= 7'h34;
    apb(1'b1, `MTR_ROUTE_ADDR, 32'h0020_0000);
    apb(1'b1, `MTR_CTRL_ADDR, 32'h1);
    settle(6);
    `CHK({grant, cdma, gin}, 7'h6c)
    apb(1'b0, `MTR_STAT_ADDR, 32'h0);
    `CHK(q, 32'h0002_0c34)
    apb(1'b1, `MTR_CTRL_ADDR, 32'h0);
    settle(2);
    `CHK(grant, 1'b0)
    apb(1'b1, `MTR_ROUTE_ADDR, 32'h0062_0000);
    settle(1);
    `CHK({vst, lck}, 2'b11)
    apb(1'b1, `MTR_ROUTE_ADDR, 32'h0);
    board_drv <= 7'h00;
  endtask

  // Both straps high hand terminals 4 and 1 to the serial engine.
  task automatic t_serial();
    @(posedge pclk);
    s0 <= 1'b1;
    s1 <= 1'b1;
    scl_o <= 1'b1;
    scl_oe <= 1'b1;
    settle(12);
    `CHK({ser, t_oe[4], t_out[4], t_oe[1], sda}, 5'h1f)
    @(posedge pclk);
    scl_o <= 1'b0;
    settle(1);
    `CHK(t_out[4], 1'b0)
    @(posedge pclk);
    s0 <= 1'b0;
    s1 <= 1'b0;
    scl_oe <= 1'b0;
    settle(6);
  endtask

  // A word from the serial EEPROM replaces the routing contents.
  task automatic t_eeprom();
    @(posedge pclk);
    ld_v <= 1'b1;
    ld_d <= 32'hf123_4567;
    @(posedge pclk);
    ld_v <= 1'b0;
    apb(1'b0, `MTR_ROUTE_ADDR, 32'h0);
    `CHK(q, 32'h0123_4567)
  endtask

  ////////////////////////////////////////////////
  // Main flow: reset for six cycles, then each scenario.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_map();
    t_dma();
    t_serial();
    t_eeprom();
    wrap_up();
  end
endmodule
